// *** rtl/afbl_consts.vh ***
// Constants for the flag register and data memory bank layout
`ifndef AFBL_CONSTS_VH
`define AFBL_CONSTS_VH
`define AFBL_FLAG_CARRY      0
`define AFBL_FLAG_NIBBLE     1
`define AFBL_FLAG_ZERO       2
`define AFBL_FLAG_SLEEP      3
`define AFBL_FLAG_TIMEOUT    4
`define AFBL_ARITH_MASK      8'h07
`define AFBL_CAUSE_RESET     2'h3
`define AFBL_BANK_OFS_BITS   7
`define AFBL_BANK_SEL_BITS   5
`define AFBL_ADDR_BITS       12
`define AFBL_CORE_LAST       7'h0B
`define AFBL_PERIPH_FIRST    7'h0C
`define AFBL_PERIPH_LAST     7'h1F
`define AFBL_RAM_FIRST       7'h20
`define AFBL_RAM_LAST        7'h6F
`define AFBL_COMMON_FIRST    7'h70
`define AFBL_FLAG_OFS        7'h03
`define AFBL_RAM_PER_BANK    8'h50
`define AFBL_RAM_BANKS       4
`define AFBL_RAM_WORDS       320
`define AFBL_RAM_ABITS       9
`define AFBL_COMMON_WORDS    16
`define AFBL_LINEAR_BASE     16'h2000
`define AFBL_LINEAR_TOP      16'h213F
`define AFBL_WB_FLAGS        4'h0
`define AFBL_WB_OP           4'h1
`define AFBL_WB_OPND         4'h2
`define AFBL_WB_RESULT       4'h3
`define AFBL_WB_MADDR        4'h4
`define AFBL_WB_MDATA        4'h5
`define AFBL_WB_FPTR         4'h6
`define AFBL_WB_LDATA        4'h7
`define AFBL_WB_EVENT        4'h8
`define AFBL_OP_NONE         4'h0
`define AFBL_OP_ADD          4'h1
`define AFBL_OP_SUB          4'h2
`define AFBL_OP_AND          4'h3
`define AFBL_OP_OR           4'h4
`define AFBL_OP_XOR          4'h5
`define AFBL_OP_RR           4'h6
`define AFBL_OP_RL           4'h7
`define AFBL_OP_CLEAR_FILE_INSTR         4'h8
`define AFBL_OP_MOVE         4'h9
`define AFBL_OP_SWAP         4'hA
`define AFBL_OP_BCLR         4'hB
`define AFBL_OP_BSET         4'hC
`define AFBL_EV_KICK         0
`define AFBL_EV_SLEEP        1
`define AFBL_EV_WDTO         2
`define AFBL_EV_POR          3
`endif

// *** rtl/afbl_ram.v ***
// Single-port byte memory with registered read data
`default_nettype none
module afbl_ram #(
  parameter WORDS = 16,
  parameter ABITS = 4
) (
  input  wire             clk_i,
  input  wire             we_i,
  input  wire [ABITS-1:0] addr_i,
  input  wire [7:0]       wdata_i,
  output reg  [7:0]       rdata_o
);
  reg [7:0] mem [0:WORDS-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // afbl_ram
`default_nettype wire

// *** rtl/afbl_map.v ***
// Data memory address decoder: banked and linear addresses to storage
`default_nettype none
`include "afbl_consts.vh"
module afbl_map (
  input  wire [15:0] addr_i,
  input  wire        linear_i,
  output reg         is_flags_o,
  output reg         is_core_o,
  output reg         is_periph_o,
  output reg         is_ram_o,
  output reg         is_common_o,
  output reg  [8:0]  ram_idx_o,
  output reg  [3:0]  common_idx_o
);
  reg [4:0]  bank;
  reg [6:0]  ofs;
  reg [15:0] lin;
  reg [8:0]  rel;

  always @* begin
    bank         = addr_i[11:7];
    ofs          = addr_i[6:0];
    lin          = addr_i - `AFBL_LINEAR_BASE;
    rel          = {2'h0, ofs} - {2'h0, `AFBL_RAM_FIRST};
    is_flags_o   = 1'b0;
    is_core_o    = 1'b0;
    is_periph_o  = 1'b0;
    is_ram_o     = 1'b0;
    is_common_o  = 1'b0;
    ram_idx_o    = 9'h000;
    common_idx_o = ofs[3:0];
    if (linear_i) begin
      // Linear window stitches the RAM of the four built banks end to end
      if (addr_i >= `AFBL_LINEAR_BASE && addr_i <= `AFBL_LINEAR_TOP) begin
        is_ram_o  = 1'b1;
        ram_idx_o = lin[8:0];
      end
    end else if (ofs <= `AFBL_CORE_LAST) begin
      is_core_o  = 1'b1;
      is_flags_o = (ofs == `AFBL_FLAG_OFS);
    end else if (ofs <= `AFBL_PERIPH_LAST) begin
      is_periph_o = 1'b1;
    end else if (ofs <= `AFBL_RAM_LAST) begin
      // Banks past the last implemented ones read as zero
      if (bank < `AFBL_RAM_BANKS) begin
        is_ram_o  = 1'b1;
        ram_idx_o = bank[2:0] * 9'h050 + rel;
      end
    end else begin
      is_common_o = 1'b1;
    end
  end
endmodule // afbl_map
`default_nettype wire

// *** rtl/afbl_core.v ***
// Flag register, ALU flag logic and banked data memory behind Wishbone
//
// The Wishbone slave port and the address map were left to the implementer.
`default_nettype none
`include "afbl_consts.vh"
// Summary of operation
// RULE1 - Clear-file on flags gives 000u u1uu
// RULE2 - Flag bits 7 to 5 read zero
// RULE3 - Timeout flag: set by kick/sleep, cleared by timeout
// RULE4 - Sleep flag: set by kick, cleared by sleep
// RULE5 - Zero flag follows zero result
// RULE6 - Nibble carry from bit 3 on add/sub
// RULE7 - Carry from bit 7 on add/sub
// RULE8 - Subtract adds two's complement; carry means no-borrow
// RULE9 - Rotates load carry with shifted-out bit
// RULE10 - Software alters flags with flag-neutral instructions
// RULE11 - Power reset sets cause flags, clears arithmetic
// RULE12 - Peripheral regs at offsets 0Ch to 1Fh
// RULE13 - Up to 80 RAM bytes per bank
// RULE14 - RAM also reachable linearly by file pointer
// RULE15 - 16 common bytes shared across banks
// RULE16 - Flag-affecting writes to flags keep ALU flags
// RULE17 - 12-bit address: 5 bank, 7 offset bits
// RULE18 - Core regs in first 12 bytes of each bank
// RULE19 - Unaffected flags hold; update with the result
module afbl_core (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        por_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:2]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg  [7:0]  flags_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg  [2:0]  state;
  reg  [4:0]  flags;
  reg  [3:0]  op;
  reg  [7:0]  opnd;
  reg  [7:0]  result;
  reg  [2:0]  bit_sel;
  reg         dest_flags;
  reg  [15:0] maddr;
  reg  [15:0] fptr;
  reg  [7:0]  mem_wdata;
  reg         mem_linear;
  reg  [7:0]  next_result;
  reg  [4:0]  next_flags;
  reg  [8:0]  sum;
  reg  [4:0]  nib;
  reg  [7:0]  addend;
  reg         aff_z;
  reg         aff_cdc;
  reg  [31:0] rd_word;
  wire [7:0]  ram_rdata;
  wire [7:0]  com_rdata;
  wire        is_flags;
  wire        is_core;
  wire        is_periph;
  wire        is_ram;
  wire        is_common;
  wire [8:0]  ram_idx;
  wire [3:0]  com_idx;
  wire [15:0] map_addr;
  wire        hit;
  wire        exec;
  wire        mem_acc;
  wire [3:0]  ex_op;
  wire [2:0]  ex_bit;
  wire        ex_dest;
  wire        ex_sub;

  assign hit      = cyc_i && stb_i && (state == ST_IDLE);
  assign exec     = hit && we_i && sel_i[0] && (adr_i == `AFBL_WB_OP);
  assign mem_acc  = hit && sel_i[0] &&
                    ((adr_i == `AFBL_WB_MDATA) || (adr_i == `AFBL_WB_LDATA));
  // Execute from the incoming op word so flags and result land on the take edge
  assign ex_op    = dat_i[3:0];
  assign ex_bit   = dat_i[6:4];
  assign ex_dest  = dat_i[7];
  assign ex_sub   = (ex_op == `AFBL_OP_SUB);
  assign map_addr = (adr_i == `AFBL_WB_LDATA) ? fptr
                  : {4'h0, maddr[`AFBL_ADDR_BITS-1:0]}; // see RULE17

  afbl_map u_map (
    .addr_i       (map_addr),
    .linear_i     (adr_i == `AFBL_WB_LDATA), // see RULE14
    .is_flags_o   (is_flags),
    .is_core_o    (is_core),
    .is_periph_o  (is_periph),
    .is_ram_o     (is_ram),
    .is_common_o  (is_common),
    .ram_idx_o    (ram_idx),
    .common_idx_o (com_idx)
  );

  // Only four banks of RAM are built; higher banks read zero
  afbl_ram #(.WORDS(`AFBL_RAM_WORDS), .ABITS(`AFBL_RAM_ABITS)) u_gpr (
    .clk_i   (clk_i),
    .we_i    (mem_acc && we_i && is_ram), // see RULE13
    .addr_i  (ram_idx),
    .wdata_i (dat_i[7:0]),
    .rdata_o (ram_rdata)
  );

  afbl_ram #(.WORDS(`AFBL_COMMON_WORDS), .ABITS(4)) u_common (
    .clk_i   (clk_i),
    .we_i    (mem_acc && we_i && is_common), // see RULE15
    .addr_i  (com_idx),
    .wdata_i (dat_i[7:0]),
    .rdata_o (com_rdata)
  );

  // Flag computation for the instruction on the bus
  always @* begin
    next_flags  = flags;
    next_result = result;
    // Carry-in supplies the +1 of the complement, so a zero nibble or
    // byte in the subtrahend still reports no-borrow
    addend      = ex_sub ? ~opnd : opnd; // see RULE8
    sum         = {1'b0, result} + {1'b0, addend} + {8'h00, ex_sub};
    nib         = {1'b0, result[3:0]} + {1'b0, addend[3:0]} + {4'h0, ex_sub};
    aff_z   = 1'b0;
    aff_cdc = 1'b0;
    case (ex_op)
      `AFBL_OP_ADD, `AFBL_OP_SUB: begin
        next_result = sum[7:0];
        next_flags[`AFBL_FLAG_CARRY]  = sum[8]; // see RULE7
        next_flags[`AFBL_FLAG_NIBBLE] = nib[4]; // see RULE6
        aff_z   = 1'b1;
        aff_cdc = 1'b1;
      end
      `AFBL_OP_AND: begin
        next_result = result & opnd;
        aff_z = 1'b1;
      end
      `AFBL_OP_OR: begin
        next_result = result | opnd;
        aff_z = 1'b1;
      end
      `AFBL_OP_XOR: begin
        next_result = result ^ opnd;
        aff_z = 1'b1;
      end
      `AFBL_OP_RR: begin
        next_result = {flags[`AFBL_FLAG_CARRY], result[7:1]};
        next_flags[`AFBL_FLAG_CARRY] = result[0]; // see RULE9
        aff_cdc = 1'b1;
      end
      `AFBL_OP_RL: begin
        next_result = {result[6:0], flags[`AFBL_FLAG_CARRY]};
        next_flags[`AFBL_FLAG_CARRY] = result[7]; // see RULE9
        aff_cdc = 1'b1;
      end
      `AFBL_OP_CLEAR_FILE_INSTR: begin
        next_result = 8'h00;
        aff_z = 1'b1;
      end
      `AFBL_OP_MOVE: next_result = opnd;
      `AFBL_OP_SWAP: next_result = {result[3:0], result[7:4]};
      `AFBL_OP_BCLR: next_result = result & ~(8'h01 << ex_bit);
      `AFBL_OP_BSET: next_result = result | (8'h01 << ex_bit);
      default: next_result = result; // see RULE19
    endcase
    if (aff_z) begin
      next_flags[`AFBL_FLAG_ZERO] = (next_result == 8'h00); // see RULE5
    end
    // Result aimed at the flag register: any flag-affecting instruction
    // blocks the write of all three arithmetic bits
    if (ex_dest) begin
      if (!aff_z && !aff_cdc) begin
        next_flags[`AFBL_FLAG_ZERO]   = next_result[`AFBL_FLAG_ZERO]; // see RULE16
        next_flags[`AFBL_FLAG_NIBBLE] = next_result[`AFBL_FLAG_NIBBLE];
        next_flags[`AFBL_FLAG_CARRY]  = next_result[`AFBL_FLAG_CARRY];
      end
      // Cause bits never written; clear-file leaves 000u u1uu, see RULE1
      next_result = {3'h0, next_flags}; // see RULE2
    end
  end

  // Register word read mux; unmapped words read zero
  always @* begin
    rd_word = 32'h0000_0000;
    if (adr_i == `AFBL_WB_FLAGS) begin
      rd_word = {27'h0, flags}; // see RULE2
    end else if (adr_i == `AFBL_WB_OP) begin
      rd_word = {24'h0, dest_flags, bit_sel, op};
    end else if (adr_i == `AFBL_WB_OPND) begin
      rd_word = {24'h0, opnd};
    end else if (adr_i == `AFBL_WB_RESULT) begin
      rd_word = {24'h0, result};
    end else if (adr_i == `AFBL_WB_MADDR) begin
      rd_word = {16'h0, maddr};
    end else if (adr_i == `AFBL_WB_FPTR) begin
      rd_word = {16'h0, fptr};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      op         <= `AFBL_OP_NONE;
      opnd       <= 8'h00;
      result     <= 8'h00;
      bit_sel    <= 3'h0;
      dest_flags <= 1'b0;
      maddr      <= 16'h0000;
      fptr       <= 16'h0000;
      mem_linear <= 1'b0;
      mem_wdata  <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (hit) begin
            if (mem_acc) begin
              // Memory read data arrives a cycle later from the RAM register
              state      <= ST_WAIT;
              mem_linear <= is_ram | is_common;
              mem_wdata  <= {is_periph, is_core, is_flags, 5'h00};
            end else begin
              state <= ST_DONE;
              ack_o <= 1'b1;
              dat_o <= rd_word;
              if (we_i && sel_i[0]) begin
                if (adr_i == `AFBL_WB_OP) begin
                  op         <= dat_i[3:0];
                  bit_sel    <= dat_i[6:4];
                  dest_flags <= dat_i[7];
                  result     <= next_result;
                end else if (adr_i == `AFBL_WB_OPND) begin
                  opnd <= dat_i[7:0];
                end else if (adr_i == `AFBL_WB_RESULT) begin
                  result <= dat_i[7:0];
                end else if (adr_i == `AFBL_WB_MADDR) begin
                  maddr <= {4'h0, dat_i[11:0]};
                end else if (adr_i == `AFBL_WB_FPTR) begin
                  fptr <= dat_i[15:0];
                end
              end
            end
          end
        end
        ST_WAIT: begin
          state <= ST_DONE;
          ack_o <= 1'b1;
          if (mem_wdata[5]) begin
            dat_o <= {27'h0, flags}; // see RULE18
          end else if (mem_linear) begin
            dat_o <= {24'h0, (is_common ? com_rdata : ram_rdata)};
          end else begin
            // Core and peripheral slots live outside this block, see RULE12
            dat_o <= 32'h0000_0000;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Flags: power reset clears arithmetic bits, other resets keep them
  always @(posedge clk_i) begin
    if (rst_i && por_i) begin
      flags <= {`AFBL_CAUSE_RESET, 3'h0}; // see RULE11
    end else if (!rst_i) begin
      if (exec) begin
        flags <= next_flags; // see RULE19
      end else if (hit && we_i && sel_i[0] && adr_i == `AFBL_WB_EVENT) begin
        // Power reset outranks timeout, sleep and kick when several bits are set
        if (dat_i[`AFBL_EV_POR]) begin
          flags <= {`AFBL_CAUSE_RESET, 3'h0}; // see RULE11
        end else if (dat_i[`AFBL_EV_WDTO]) begin
          flags[`AFBL_FLAG_TIMEOUT] <= 1'b0; // see RULE3
        end else if (dat_i[`AFBL_EV_SLEEP]) begin
          flags[`AFBL_FLAG_TIMEOUT] <= 1'b1; // see RULE3
          flags[`AFBL_FLAG_SLEEP]   <= 1'b0; // see RULE4
        end else if (dat_i[`AFBL_EV_KICK]) begin
          flags[`AFBL_FLAG_TIMEOUT] <= 1'b1;
          flags[`AFBL_FLAG_SLEEP]   <= 1'b1; // see RULE4
        end
      end
    end
  end

  // Image lags the flags by a cycle; a power reset preloads it
  always @(posedge clk_i) begin
    if (rst_i && por_i) begin
      flags_o <= {3'h0, `AFBL_CAUSE_RESET, 3'h0};
    end else begin
      flags_o <= {3'h0, flags};
    end
  end
endmodule // afbl_core
`default_nettype wire

// *** sim/afbl_core_assertions.sv ***
// Port-level checker for the flag register block
`default_nettype none
module afbl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:2]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic req   = cyc_i && stb_i;
  wire logic slow  = (adr_i == 4'h5) || (adr_i == 4'h7);
  wire logic op_wr = ack_o && we_i && (adr_i == 4'h1);
  wire logic ev_wr = ack_o && we_i && (adr_i == 4'h8);
  default clocking
    @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  hi_zero_a: assert property (flags_o[7:5] == 3'h0)
    else $error("flag bits 7 to 5 not zero");
  flag_read_a: assert property (
    ack_o && !we_i && adr_i == 4'h0 |-> dat_o == {24'h0, flags_o})
    else $error("flag read differs from flags");
  cause_hold_a: assert property (
    !$stable(flags_o[4:3]) |-> $past(ev_wr))
    else $error("cause flags moved without event");
  arith_hold_a: assert property (
    !$stable(flags_o[2:0]) |-> $past(op_wr) || $past(ev_wr))
    else $error("arith flags moved without op");
  clr_flags_a: assert property (
    op_wr && dat_i[7:0] == 8'h88 |=> flags_o[2]
      && flags_o[1:0] == $past(flags_o[1:0]) && $stable(flags_o[4:3]))
    else $error("clear on flags wrong");
  fast_ack_a: assert property ($rose(stb_i) && !slow |=> ack_o)
    else $error("register ack late");
  slow_ack_a: assert property ($rose(stb_i) && slow |=> !ack_o ##1 ack_o)
    else $error("memory ack not two cycles");
  ack_once_a: assert property (ack_o |-> $past(req) ##1 !ack_o)
    else $error("ack without request or too long");
  c_clr: cover property (op_wr && dat_i[7:0] == 8'h88);
  c_ev: cover property (ev_wr);
  c_slow: cover property (ack_o && slow);
endmodule // afbl_chk
bind afbl_core afbl_chk u_afbl_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .flags_o(flags_o));
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the flag register and bank layout block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        por_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [5:2]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  flags_o;
  logic [7:0]  exp_q[$];
  logic [7:0]  fl, acc, opnd, e, exp_m;
  logic [2:0]  n3;
  int          miscompares = 0;
  int          checks = 0;
  int          i, k;
  afbl_core u_afbl_core (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .flags_o(flags_o));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the ack edge, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    wb(1'b0, a, 16'h0);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      exp_m = exp_q.pop_front();
      cmp(dat_o, {24'h0, exp_m});
      if (adr_i === 4'h0) cmp_flags(flags_o, exp_m);
    end
  end
  function automatic logic [15:0] alu(input logic [3:0] op, input logic [2:0] n,
                                      input logic [7:0] a, b, f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r, bb;
    r = a;
    case (op)
      4'h1, 4'h2: begin
        bb = (op == 4'h2) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h0, op[1]};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op[1]};
        r = s[7:0];
        f[1:0] = {h[4], s[8]};
      end
      4'h3: r = a & b;
      4'h4: r = a | b;
      4'h5: r = a ^ b;
      4'h6: {r, f[0]} = {f[0], a};
      4'h7: {f[0], r} = {a, f[0]};
      4'h8: r = 8'h00;
      4'h9: r = b;
      4'hA: r = {a[3:0], a[7:4]};
      4'hB: r = a & ~(8'h01 << n);
      4'hC: r = a | (8'h01 << n);
      default: r = a;
    endcase
    if (op inside {[4'h1:4'h5], 4'h8}) f[2] = (r == 8'h00);
    return {f, r};
  endfunction
  initial begin
    k = $urandom(9);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    fl = 8'h18;
    rd(4'h0, fl);
    // Last two blocks force zero results with equal, then negated, operands
    for (i = 0; i < 60; i++) begin
      k = 1 + (i % 12);
      acc = 8'($urandom);
      opnd = (i < 36) ? 8'($urandom) : (i < 48) ? acc : 8'h00 - acc;
      n3 = 3'($urandom);
      wr(4'h3, {8'h0, acc});
      wr(4'h2, {8'h0, opnd});
      wr(4'h1, {8'h0, 1'b0, n3, k[3:0]});
      {fl, e} = alu(k[3:0], n3, acc, opnd, fl);
      rd(4'h3, e);
      rd(4'h0, fl);
    end
    $display("test arithmetic done");
    {fl, e} = alu(4'h1, 3'h0, e, opnd, fl);
    wr(4'h1, 16'h0081);
    rd(4'h0, fl);
    wr(4'h2, 16'h0002);
    wr(4'h1, 16'h0089);
    fl[2:0] = 3'h2;
    rd(4'h0, fl);
    wr(4'h1, 16'h0088);
    fl[2] = 1'b1;
    rd(4'h0, fl);
    for (i = 0; i < 4; i++) begin
      wr(4'h8, 16'h1 << i);
      fl[4:3] = (i == 0) ? 2'b11 : (i == 1) ? 2'b10 : {1'b0, fl[3]};
      if (i == 3) fl = 8'h18;
      rd(4'h0, fl);
    end
    wr(4'h1, 16'h0088);
    fl[2] = 1'b1;
    por_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, fl);
    $display("test flags done");
    wr(4'h4, 16'h00A0);
    wr(4'h5, 16'h005A);
    wr(4'h6, 16'h2050);
    rd(4'h7, 8'h5A);
    wr(4'h6, 16'h204F);
    wr(4'h7, 16'h00C3);
    wr(4'h4, 16'h006F);
    rd(4'h5, 8'hC3);
    wr(4'h4, 16'h0070);
    wr(4'h5, 16'h0077);
    wr(4'h4, 16'h01F0);
    rd(4'h5, 8'h77);
    wr(4'h4, 16'h0103);
    rd(4'h5, fl);
    wr(4'h4, 16'h018C);
    wr(4'h5, 16'h00FF);
    rd(4'h5, 8'h00);
    wr(4'hF, 16'h00FF);
    rd(4'hF, 8'h00);
    $display("test memory map done");
    end_sim();
  end
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
